// File: rtl/mdc_pkg.sv
package mdc_pkg;
  localparam logic [7:0]  ADDR_DRIVE_LOOP    = 8'h95;
  localparam logic [7:0]  ADDR_STARTUP_SENSE = 8'h96;
  localparam logic [15:0] RST_DRIVE_LOOP     = 16'h0000;
  localparam logic [15:0] RST_STARTUP_SENSE  = 16'h0000;
  localparam logic [15:0] MASK_STARTUP_SENSE = 16'hff7f;
  localparam int          CLK_HZ             = 50_000_000;
  localparam int          FREQ_LOW_HZ        = 25_000;
  localparam int          FREQ_HIGH_HZ       = 50_000;
  localparam int          PERIOD_LOW_CYC     = CLK_HZ / FREQ_LOW_HZ;
  localparam int          PERIOD_HIGH_CYC    = CLK_HZ / FREQ_HIGH_HZ;
  // Duty in per-mille
  localparam logic [9:0]  DUTY_FLOOR_LOW     = 10'h032;
  localparam logic [9:0]  DUTY_FLOOR_HIGH    = 10'h064;
  localparam logic [9:0]  DUTY_CUTOFF        = 10'h00f;
  localparam logic [9:0]  DUTY_FULL          = 10'h3e8;

  typedef struct packed {
    logic       speed_input_type;
    logic       drive_switch_freq_sel;
    logic [1:0] motor_const_lock_limits;
    logic       inductive_surge_guard_en;
    logic       mechanical_surge_guard_en;
    logic       mechanical_surge_guard_mode;
    logic       sense_release_mode;
    logic       closed_loop_disable;
    logic [2:0] closed_loop_ramp_rate;
    logic [1:0] minimum_duty_select;
    logic [1:0] phase_edge_speed;
  } mdc_drive_loop_t;

  typedef struct packed {
    logic [1:0] start_advance_angle;
    logic [3:0] inductive_sense_threshold;
    logic [1:0] inductive_sense_clock_sel;
    logic       reserved;
    logic [1:0] control_coefficient;
    logic [4:0] switch_gap_time;
  } mdc_startup_sense_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mdc_req_t;

  // Torque-constant limits in quarters of nominal
  typedef struct packed {
    logic [3:0] upper_q;
    logic [3:0] lower_q;
  } mdc_limits_t;
endpackage

// File: rtl/mdc_duty_shaper.sv
`timescale 1ns/1ps
module mdc_duty_shaper (
  // Settings
  input  wire logic [1:0] i_min_sel,
  // Duty command and result, per-mille
  input  wire logic [9:0] i_cmd,
  output logic      [9:0] o_duty
);
  always_comb begin
    if (i_cmd < mdc_pkg::DUTY_CUTOFF) begin
      o_duty = i_min_sel[1] ? mdc_pkg::DUTY_FULL : 10'h000;
    end else begin
      o_duty = i_min_sel[0] ? ((i_cmd < mdc_pkg::DUTY_FLOOR_HIGH) ? mdc_pkg::DUTY_FLOOR_HIGH : i_cmd)
                            : ((i_cmd < mdc_pkg::DUTY_FLOOR_LOW) ? mdc_pkg::DUTY_FLOOR_LOW : i_cmd);
    end
  end
endmodule // mdc_duty_shaper

// File: rtl/mdc_limit_decode.sv
`timescale 1ns/1ps
module mdc_limit_decode (
  input  wire logic [1:0]          i_sel,
  output mdc_pkg::mdc_limits_t     o_lim
);
  always_comb begin
    o_lim.upper_q = i_sel[0] ? 4'h8 : 4'h6;
    o_lim.lower_q = i_sel[1] ? 4'h2 : 4'h3;
  end
endmodule // mdc_limit_decode

// File: rtl/mdc_config_regs.sv
`timescale 1ns/1ps
module mdc_config_regs #(
  // Width of the switching-period counter
  parameter int CNT_W = 12
) (
  // Clock, reset, enable
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_ce,
  // Register access
  input  wire mdc_pkg::mdc_req_t    i_req,
  output logic      [15:0]          o_rdata,
  output logic                      o_rvalid,
  // Settings applied to the drive
  output mdc_pkg::mdc_drive_loop_t  o_drive_cfg,
  output mdc_pkg::mdc_startup_sense_t o_sense_cfg,
  output mdc_pkg::mdc_limits_t      o_kt_limits,
  output logic                      o_speed_is_pwm,
  output logic                      o_switch_tick,
  output logic                      o_ind_guard_on,
  output logic                      o_mech_guard_on,
  output logic                      o_mech_clamp_fixed,
  output logic                      o_release_float,
  // Closed-loop handover
  input  wire logic                 i_above_handover,
  output logic                      o_closed_loop,
  // Duty path, per-mille
  input  wire logic [9:0]           i_duty_cmd,
  output logic      [9:0]           o_duty_out,
  output logic      [2:0]           o_ramp_rate,
  output logic      [1:0]           o_edge_speed
);
  // Register bank geometry
  localparam int unsigned NREG      = 2;
  localparam int unsigned IDX_DRIVE = 0;
  localparam int unsigned IDX_SENSE = 1;

  // Per-entry address, reset word and writable bits; entry 0 is the drive register
  localparam logic [NREG-1:0][7:0]  ENTRY_ADDR = {mdc_pkg::ADDR_STARTUP_SENSE, mdc_pkg::ADDR_DRIVE_LOOP};
  localparam logic [NREG-1:0][15:0] ENTRY_RST  = {mdc_pkg::RST_STARTUP_SENSE, mdc_pkg::RST_DRIVE_LOOP};
  localparam logic [NREG-1:0][15:0] ENTRY_MASK = {mdc_pkg::MASK_STARTUP_SENSE, 16'hffff};

  // Refuse a period counter that cannot reach the slower switching period
  if (CNT_W < 2 || CNT_W > 30) begin : g_bad_cnt_w
    $error("period counter width out of range");
  end else if ((1 << CNT_W) < mdc_pkg::PERIOD_LOW_CYC) begin : g_short_cnt_w
    $error("period counter too narrow for the slow switching rate");
  end

  // A period below two cycles would leave the tick stuck high
  if (mdc_pkg::PERIOD_HIGH_CYC < 2) begin : g_bad_period
    $error("fast switching period too short");
  end

  // Loop handover state, one-hot
  typedef enum logic [1:0] {
    LOOP_OPEN   = 2'b01,
    LOOP_CLOSED = 2'b10
  } mdc_loop_t;

  // Whole module state
  typedef struct packed {
    logic [NREG-1:0][15:0] bank;
    logic [15:0]           rdata;
    logic                  rvalid;
    logic [CNT_W-1:0]      per_cnt;
    logic                  tick;
    mdc_loop_t             loop;
    logic [9:0]            duty;
  } mdc_state_t;

  // State and its next value
  mdc_state_t                  st_ff;
  mdc_state_t                  nxt_st;

  // Views of the stored registers
  mdc_pkg::mdc_drive_loop_t    drive;
  mdc_pkg::mdc_startup_sense_t sense;

  // Entry decode
  logic [NREG-1:0]             entry_hit;
  logic [NREG-1:0]             entry_wr;
  logic [NREG-1:0][15:0]       entry_wdata;
  logic [NREG-1:0][15:0]       entry_rdata;
  logic                        rd_taken;
  logic [15:0]                 rd_word;

  // Switching period
  logic [CNT_W-1:0]            period;
  logic [CNT_W-1:0]            period_last;
  logic                        period_end;

  // Loop handover and duty path
  logic                        loop_may_close;
  logic                        loop_must_open;
  logic [9:0]                  shaped;

  assign drive = st_ff.bank[IDX_DRIVE];
  assign sense = st_ff.bank[IDX_SENSE];

  // One decoder per bank entry
  for (genvar r = 0; r < NREG; r++) begin : g_entry
    assign entry_hit[r]   = (i_req.addr == ENTRY_ADDR[r]);
    assign entry_wr[r]    = i_req.wr & entry_hit[r];
    // Read-only bits neither store nor return anything but zero
    assign entry_wdata[r] = i_req.wdata & ENTRY_MASK[r];
    assign entry_rdata[r] = st_ff.bank[r] & ENTRY_MASK[r];
  end

  assign rd_taken = i_req.rd;

  mdc_duty_shaper u_shaper (
    .i_min_sel (drive.minimum_duty_select),
    .i_cmd     (i_duty_cmd),
    .o_duty    (shaped)
  );

  mdc_limit_decode u_limits (
    .i_sel (drive.motor_const_lock_limits),
    .o_lim (o_kt_limits)
  );

  // Switching period follows the frequency select bit
  assign period      = drive.drive_switch_freq_sel ? CNT_W'(mdc_pkg::PERIOD_HIGH_CYC)
                                                   : CNT_W'(mdc_pkg::PERIOD_LOW_CYC);
  assign period_last = period - CNT_W'(1);
  // Greater-or-equal so that a switch to the short period never overruns
  assign period_end  = (st_ff.per_cnt >= period_last);

  assign loop_must_open = drive.closed_loop_disable;
  assign loop_may_close = !drive.closed_loop_disable && i_above_handover;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.tick   = 1'b0;
    rd_word       = 16'h0000;

    // Writes to unmapped addresses fall through untouched
    for (int r = 0; r < NREG; r++) begin
      if (entry_wr[r]) begin
        nxt_st.bank[r] = entry_wdata[r];
      end
      if (entry_hit[r]) begin
        rd_word = rd_word | entry_rdata[r];
      end
    end

    // Reads see the word before any write in the same cycle
    if (rd_taken) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_word;
    end

    if (period_end) begin
      nxt_st.per_cnt = '0;
      nxt_st.tick    = 1'b1;
    end else begin
      nxt_st.per_cnt = st_ff.per_cnt + CNT_W'(1);
    end

    case (st_ff.loop)
      LOOP_OPEN: begin
        if (loop_may_close) begin
          nxt_st.loop = LOOP_CLOSED;
        end
      end
      LOOP_CLOSED: begin
        if (loop_must_open) begin
          nxt_st.loop = LOOP_OPEN;
        end
      end
      default: begin
        nxt_st.loop = LOOP_OPEN;
      end
    endcase

    nxt_st.duty = shaped;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff      <= '0;
      st_ff.bank <= ENTRY_RST;
      st_ff.loop <= LOOP_OPEN;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // Register access
  assign o_rdata            = st_ff.rdata;
  assign o_rvalid           = st_ff.rvalid;

  // Stored settings
  assign o_drive_cfg        = drive;
  assign o_sense_cfg        = sense;

  // Settings applied to the drive
  assign o_speed_is_pwm     = drive.speed_input_type;
  assign o_switch_tick      = st_ff.tick;
  assign o_ind_guard_on     = drive.inductive_surge_guard_en;
  assign o_mech_guard_on    = drive.mechanical_surge_guard_en;
  assign o_mech_clamp_fixed = drive.mechanical_surge_guard_mode;
  assign o_release_float    = drive.sense_release_mode;

  // Loop handover
  assign o_closed_loop      = (st_ff.loop == LOOP_CLOSED);

  // Duty path
  assign o_duty_out         = st_ff.duty;
  assign o_ramp_rate        = drive.closed_loop_ramp_rate;
  assign o_edge_speed       = drive.phase_edge_speed;
endmodule // mdc_config_regs

// File: bench/mdc_config_regs_monitor.sv
`timescale 1ns/1ps
module mdc_config_regs_monitor (
  // Clock and inputs
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire mdc_pkg::mdc_req_t i_req,
  input wire logic i_above_handover,
  input wire logic [9:0] i_duty_cmd,
  // Outputs
  input wire logic o_rvalid,
  input wire mdc_pkg::mdc_drive_loop_t o_drive_cfg,
  input wire mdc_pkg::mdc_limits_t o_kt_limits,
  input wire logic o_speed_is_pwm,
  input wire logic o_ind_guard_on,
  input wire logic o_mech_guard_on,
  input wire logic o_mech_clamp_fixed,
  input wire logic o_release_float,
  input wire logic o_closed_loop,
  input wire logic [9:0] o_duty_out,
  input wire logic [2:0] o_ramp_rate,
  input wire logic [1:0] o_edge_speed
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic [9:0] fl;
  logic       hold;
  assign fl = o_drive_cfg[2] ? 10'h064 : 10'h032;
  assign hold = i_ce && !i_req.wr;
  a_read_answer: assert property (i_ce && i_req.rd |=> o_rvalid) else $error("no read answer");
  a_mode_bits:
    assert property ({o_speed_is_pwm, o_ind_guard_on, o_mech_guard_on, o_mech_clamp_fixed, o_release_float}
      == {o_drive_cfg[15], o_drive_cfg[11:8]}) else $error("mode bits");
  a_lock_limits:
    assert property (o_kt_limits == {o_drive_cfg[12] ? 4'h8 : 4'h6, o_drive_cfg[13] ? 4'h2 : 4'h3}) else $error("limits");
  a_loop_set:
    assert property (hold && i_above_handover && !o_drive_cfg[7] |=> o_closed_loop) else $error("no handover");
  a_loop_clear: assert property (hold && o_drive_cfg[7] |=> !o_closed_loop) else $error("left open loop");
  a_duty_cut:
    assert property (hold && i_duty_cmd < 10'h00f |=> o_duty_out == (o_drive_cfg[3] ? 10'h3e8 : 10'h000))
      else $error("duty cut");
  a_duty_floor:
    assert property (hold && i_duty_cmd > 10'h00e |=> o_duty_out == ($past(i_duty_cmd) > fl ? $past(i_duty_cmd) : fl))
      else $error("duty floor");
  a_field_pass:
    assert property ({o_ramp_rate, o_edge_speed} == {o_drive_cfg[6:4], o_drive_cfg[1:0]}) else $error("fields");
endmodule // mdc_config_regs_monitor
bind mdc_config_regs mdc_config_regs_monitor u_mon (.i_clk, .i_srst, .i_ce, .i_req, .i_above_handover, .i_duty_cmd,
  .o_rvalid, .o_drive_cfg, .o_kt_limits, .o_speed_is_pwm, .o_ind_guard_on, .o_mech_guard_on, .o_mech_clamp_fixed,
  .o_release_float, .o_closed_loop, .o_duty_out, .o_ramp_rate, .o_edge_speed);

// File: bench/mdc_host_model.sv
`timescale 1ns/1ps
module mdc_host_model (
  // Clock
  input  wire logic        i_clk,
  // Request
  output mdc_pkg::mdc_req_t o_req
);
  initial o_req = '0;
  // Released lines show inverted data so stale values never match
  task automatic access(input logic w, r, input logic [7:0] a, input logic [15:0] d);
    o_req <= '{w, r, a, d};
    @(posedge i_clk);
    o_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // mdc_host_model

// File: bench/mdc_config_regs_bench.sv
`timescale 1ns/1ps
module mdc_config_regs_bench;
  logic i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_above_handover = 1'b0, o_rvalid, o_switch_tick, o_closed_loop;
  logic [9:0] i_duty_cmd = 10'h000, o_duty_out;
  logic [15:0] o_rdata;
  mdc_pkg::mdc_req_t i_req;
  mdc_pkg::mdc_limits_t o_kt_limits;
  mdc_pkg::mdc_drive_loop_t o_drive_cfg;
  mdc_pkg::mdc_startup_sense_t o_sense_cfg;
  logic o_speed_is_pwm, o_ind_guard_on, o_mech_guard_on, o_mech_clamp_fixed, o_release_float;
  logic [2:0] o_ramp_rate;
  logic [1:0] o_edge_speed;
  int mismatches = 0, samples_checked = 0, n;
  mdc_host_model host (.i_clk, .o_req(i_req));
  mdc_config_regs dut (.i_clk, .i_srst, .i_ce, .i_req, .o_rdata, .o_rvalid, .o_drive_cfg, .o_sense_cfg,
    .o_kt_limits, .o_speed_is_pwm, .o_switch_tick, .o_ind_guard_on, .o_mech_guard_on, .o_mech_clamp_fixed,
    .o_release_float, .i_above_handover, .o_closed_loop, .i_duty_cmd, .o_duty_out, .o_ramp_rate, .o_edge_speed);
  initial forever #10 i_clk = ~i_clk;
  task automatic chk(input string s, input logic [15:0] v, e);
    samples_checked++;
    if (v !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", s, e, v);
    end
  endtask
  // Write d, or read and expect d
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    host.access(w, !w, a, d);
    #1;
    if (!w) chk("rdata", o_rvalid === 1'b1 ? o_rdata : 16'hxxxx, d);
  endtask
  task automatic duty(input logic [9:0] c, e);
    @(posedge i_clk);
    i_duty_cmd <= c;
    repeat (2) @(negedge i_clk);
    chk("duty", 16'(o_duty_out), 16'(e));
  endtask
  task automatic t_regs;
    acc(0, 8'h95, 16'h0000);
    acc(0, 8'h96, 16'h0000);
    acc(1, 8'h95, 16'ha5c3);
    acc(1, 8'h96, 16'hffff);
    acc(1, 8'h97, 16'h1234);
    chk("drive cfg", 16'(o_drive_cfg), 16'ha5c3);
    chk("sense cfg", 16'(o_sense_cfg), 16'hff7f);
    chk("mode pins", {11'h000, o_speed_is_pwm, o_ind_guard_on, o_mech_guard_on, o_mech_clamp_fixed, o_release_float},
      16'h0015);
    chk("ramp edge", {11'h000, o_ramp_rate, o_edge_speed}, 16'h0013);
    @(posedge i_clk);
    i_ce <= 1'b0;
    host.access(1'b1, 1'b0, 8'h95, 16'h0000);
    i_ce <= 1'b1;
    acc(0, 8'h95, 16'ha5c3);
    acc(0, 8'h96, 16'hff7f);
    acc(0, 8'h97, 16'h0000);
    $display("regs done");
  endtask
  task automatic t_modes;
    for (int s = 0; s < 4; s++) begin
      acc(1, 8'h95, 16'(s * 16'h1004));
      chk("limits", 16'(o_kt_limits), {8'h00, s[0] ? 4'h8 : 4'h6, s[1] ? 4'h2 : 4'h3});
      duty(10'h00e, s[1] ? 10'h3e8 : 10'h000);
      duty(10'h00f, s[0] ? 10'h064 : 10'h032);
      duty(10'h05a, s[0] ? 10'h064 : 10'h05a);
    end
    $display("modes done");
  endtask
  task automatic t_loop;
    acc(1, 8'h95, 16'h0000);
    @(posedge i_clk);
    i_above_handover <= 1'b1;
    repeat (2) @(negedge i_clk);
    chk("closed", 16'(o_closed_loop), 16'h0001);
    acc(1, 8'h95, 16'h0080);
    repeat (2) @(negedge i_clk);
    chk("closed", 16'(o_closed_loop), 16'h0000);
    for (int f = 0; f < 2; f++) begin
      acc(1, 8'h95, 16'(f) << 14);
      repeat (2) begin
        n = 0;
        do begin @(negedge i_clk); n++; end while (o_switch_tick !== 1'b1 && n < 2100);
      end
      chk("tick gap", 16'(n), f ? 16'h03e8 : 16'h07d0);
    end
    $display("loop done");
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs;
    t_modes;
    t_loop;
    end_sim;
  end
  initial begin
    #300000;
    mismatches++;
    end_sim;
  end
endmodule // mdc_config_regs_bench
